// ### hw/acs_regs.svh
// register offsets, field positions, reset values and timing counts of the conversion sequencer
// assumes a 32-bit APB register bus with one aligned word per register
`ifndef ACS_REGS_SVH
`define ACS_REGS_SVH

// byte offsets
`define ACS_OFF_CTRL0 8'h00
`define ACS_OFF_CTRL1 8'h04
`define ACS_OFF_CTRL2 8'h08
`define ACS_OFF_RES_HI 8'h0C
`define ACS_OFF_RES_LO 8'h10
`define ACS_OFF_INT_STAT 8'h14
`define ACS_OFF_INT_CLR 8'h18
`define ACS_OFF_INT_EN 8'h1C
`define ACS_OFF_GIE 8'h20

// converter_control_0 fields
`define ACS_C0_POWER 0
`define ACS_C0_START 1
`define ACS_C0_FORMAT 2
`define ACS_C0_BUSY 3
`define ACS_C0_CHAN_LSB 4
// converter_control_1 fields
`define ACS_C1_DIV_LSB 0
`define ACS_C1_SRC_LSB 4
// converter_control_2 fields
`define ACS_C2_REF_LSB 0
`define ACS_C2_AMP_EN 2
`define ACS_C2_AMP_IN 3
`define ACS_C2_GAIN_LSB 4
// interrupt status, clear and enable: one event bit
`define ACS_INT_DONE 0

// reset values
`define ACS_RST_CTRL0 8'h00
`define ACS_RST_CTRL1 8'h00
`define ACS_RST_CTRL2 8'h00

// timing in conversion clock periods
`define ACS_SAMPLE_PERIODS 4'h4
`define ACS_CONVERT_PERIODS 4'hC
`define ACS_TOTAL_PERIODS 5'h10
// input source code that selects the external channel
`define ACS_SRC_EXTERNAL 4'h0

`endif

// ### hw/acs_pkg.sv
// types shared by the conversion sequencer and its surroundings
// assumes acs_regs.svh carries all numeric constants
package acs_pkg;
    // sequencer states, gray coded along idle, sample, convert
    typedef enum logic [1:0] {
        ACS_IDLE = 2'b00,
        ACS_SAMPLE = 2'b01,
        ACS_CONVERT = 2'b11
    } acs_state_e;

    // controls toward the analog converter macro
    typedef struct packed {
        logic power;
        logic clk_tick;
        logic sample;
        logic convert;
        logic channel_connect;
        logic [3:0] channel;
        logic [3:0] source;
        logic [1:0] ref_sel;
        logic amp_en;
        logic amp_in;
        logic [1:0] amp_gain;
    } acs_analog_s;
endpackage

// ### hw/acs_top.sv
// APB controlled sequencer for one successive-approximation converter
// assumes the analog macro follows ANALOG and presents its code on ADC_CODE by the last convert period
`include "acs_regs.svh"

module acs_top #(
    parameter int DIV_W = 3,
    parameter int CODE_W = 12
) (
    // clock and reset
    input wire logic CLK,
    input wire logic RESET,
    // apb slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // analog converter macro
    output acs_pkg::acs_analog_s ANALOG,
    input wire logic [CODE_W-1:0] ADC_CODE,
    // interrupt
    output logic IRQ
);
    import acs_pkg::*;

    logic [7:0] ctrl0_q;
    logic [7:0] ctrl1_q;
    logic [7:0] ctrl2_q;
    logic [7:0] res_hi_q;
    logic [7:0] res_lo_q;
    logic int_stat_q;
    logic int_en_q;
    logic gie_q;
    logic start_prev_q;
    logic [6:0] div_cnt_q;
    logic [3:0] phase_q;
    acs_state_e state_q;
    logic [CODE_W-1:0] code_meta_q;
    logic [CODE_W-1:0] code_sync_q;
    logic [31:0] prdata_q;
    logic slverr_q;

    logic power;
    logic fmt;
    logic [DIV_W-1:0] div_sel;
    logic [3:0] src_sel;
    logic [3:0] chan_sel;
    logic tick;
    logic [6:0] div_limit;
    logic start_fall;
    logic done_evt;
    logic busy;
    logic wr_acc;
    logic setup;
    logic [31:0] rd_word;
    logic rd_err;

    // field views of the control registers
    assign power = ctrl0_q[`ACS_C0_POWER];
    assign fmt = ctrl0_q[`ACS_C0_FORMAT];
    assign chan_sel = ctrl0_q[`ACS_C0_CHAN_LSB +: 4];
    assign div_sel = ctrl1_q[`ACS_C1_DIV_LSB +: DIV_W];
    assign src_sel = ctrl1_q[`ACS_C1_SRC_LSB +: 4];
    assign busy = (state_q != ACS_IDLE);

    // apb phases: data registered in setup, zero-wait access
    assign setup = PSEL && !PENABLE;
    assign wr_acc = PSEL && PENABLE && PWRITE;
    assign PREADY = 1'b1;
    assign PRDATA = prdata_q;
    assign PSLVERR = slverr_q && PSEL && PENABLE;

    // read mux over the register map
    always_comb begin
        rd_word = 32'h0000_0000;
        rd_err = 1'b0;
        case (PADDR)
            `ACS_OFF_CTRL0: begin
                rd_word[7:0] = ctrl0_q;
                rd_word[`ACS_C0_BUSY] = busy;
            end
            `ACS_OFF_CTRL1: rd_word[7:0] = ctrl1_q;
            `ACS_OFF_CTRL2: rd_word[7:0] = ctrl2_q;
            `ACS_OFF_RES_HI: rd_word[7:0] = res_hi_q;
            `ACS_OFF_RES_LO: rd_word[7:0] = res_lo_q;
            `ACS_OFF_INT_STAT: rd_word[`ACS_INT_DONE] = int_stat_q;
            `ACS_OFF_INT_CLR: rd_word = 32'h0000_0000;
            `ACS_OFF_INT_EN: rd_word[`ACS_INT_DONE] = int_en_q;
            `ACS_OFF_GIE: rd_word[0] = gie_q;
            default: rd_err = 1'b1;
        endcase
    end

    // capture read data and error during setup
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            prdata_q <= 32'h0000_0000;
            slverr_q <= 1'b0;
        end else if (setup) begin
            prdata_q <= PWRITE ? 32'h0000_0000 : rd_word;
            slverr_q <= rd_err;
        end
    end

    // control register writes; busy bit is read only
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            ctrl0_q <= `ACS_RST_CTRL0;
            ctrl1_q <= `ACS_RST_CTRL1;
            ctrl2_q <= `ACS_RST_CTRL2;
            int_en_q <= 1'b0;
            gie_q <= 1'b0;
        end else if (wr_acc) begin
            case (PADDR)
                `ACS_OFF_CTRL0: begin
                    ctrl0_q <= PWDATA[7:0];
                    ctrl0_q[`ACS_C0_BUSY] <= 1'b0;
                end
                `ACS_OFF_CTRL1: ctrl1_q <= PWDATA[7:0];
                `ACS_OFF_CTRL2: ctrl2_q <= PWDATA[7:0];
                `ACS_OFF_INT_EN: int_en_q <= PWDATA[`ACS_INT_DONE];
                `ACS_OFF_GIE: gie_q <= PWDATA[0];
                default: ;
            endcase
        end
    end

    // start bit history for falling edge detection
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            start_prev_q <= 1'b0;
        end else begin
            start_prev_q <= ctrl0_q[`ACS_C0_START];
        end
    end

    // pulse completes on its high to low step; ignored while busy or unpowered
    assign start_fall = start_prev_q && !ctrl0_q[`ACS_C0_START] && power && !busy;

    // conversion clock divider, restarted with each conversion
    assign div_limit = 7'((8'h01 << div_sel) - 8'h01);
    assign tick = power && (div_cnt_q == div_limit);

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            div_cnt_q <= 7'h00;
        end else if (!power || start_fall || tick) begin
            div_cnt_q <= 7'h00;
        end else begin
            div_cnt_q <= div_cnt_q + 7'h01;
        end
    end

    // last tick of the convert phase ends the conversion
    assign done_evt = (state_q == ACS_CONVERT) && tick && (phase_q == `ACS_CONVERT_PERIODS - 4'h1) && power;

    // sampling then conversion, counted in conversion clock periods
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            state_q <= ACS_IDLE;
            phase_q <= 4'h0;
        end else if (!power) begin
            state_q <= ACS_IDLE;
            phase_q <= 4'h0;
        end else begin
            case (state_q)
                ACS_IDLE: begin
                    if (start_fall) begin
                        state_q <= ACS_SAMPLE;
                        phase_q <= 4'h0;
                    end
                end
                ACS_SAMPLE: begin
                    if (tick) begin
                        if (phase_q == `ACS_SAMPLE_PERIODS - 4'h1) begin
                            state_q <= ACS_CONVERT;
                            phase_q <= 4'h0;
                        end else begin
                            phase_q <= phase_q + 4'h1;
                        end
                    end
                end
                ACS_CONVERT: begin
                    if (tick) begin
                        if (done_evt) begin
                            state_q <= ACS_IDLE;
                            phase_q <= 4'h0;
                        end else begin
                            phase_q <= phase_q + 4'h1;
                        end
                    end
                end
                default: begin
                    state_q <= ACS_IDLE;
                    phase_q <= 4'h0;
                end
            endcase
        end
    end

    // converter code crosses in from the analog macro
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            code_meta_q <= '0;
            code_sync_q <= '0;
        end else begin
            code_meta_q <= ADC_CODE;
            code_sync_q <= code_meta_q;
        end
    end

    // result store: format 0 left aligned, format 1 right aligned
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            res_hi_q <= 8'h00;
            res_lo_q <= 8'h00;
        end else if (done_evt) begin
            if (fmt) begin
                res_hi_q <= {4'h0, code_sync_q[11:8]};
                res_lo_q <= code_sync_q[7:0];
            end else begin
                res_hi_q <= code_sync_q[11:4];
                res_lo_q <= {code_sync_q[3:0], 4'h0};
            end
        end
    end

    // sticky completion flag; a new event beats a clear
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            int_stat_q <= 1'b0;
        end else if (done_evt) begin
            int_stat_q <= 1'b1;
        end else if (wr_acc && PADDR == `ACS_OFF_INT_CLR && PWDATA[`ACS_INT_DONE]) begin
            int_stat_q <= 1'b0;
        end
    end

    // level request gated by both enables
    assign IRQ = int_stat_q && int_en_q && gie_q;

    // controls to the analog macro
    always_comb begin
        ANALOG = '0;
        ANALOG.power = power;
        ANALOG.clk_tick = tick;
        ANALOG.sample = (state_q == ACS_SAMPLE);
        ANALOG.convert = (state_q == ACS_CONVERT);
        ANALOG.channel_connect = power && (src_sel == `ACS_SRC_EXTERNAL);
        ANALOG.channel = chan_sel;
        ANALOG.source = src_sel;
        ANALOG.ref_sel = ctrl2_q[`ACS_C2_REF_LSB +: 2];
        ANALOG.amp_en = ctrl2_q[`ACS_C2_AMP_EN];
        ANALOG.amp_in = ctrl2_q[`ACS_C2_AMP_IN];
        ANALOG.amp_gain = ctrl2_q[`ACS_C2_GAIN_LSB +: 2];
    end

    // helper: system cycles spent busy in the current conversion
    logic [11:0] busy_cyc_q;
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            busy_cyc_q <= 12'h000;
        end else if (!busy) begin
            busy_cyc_q <= 12'h000;
        end else begin
            busy_cyc_q <= busy_cyc_q + 12'h001;
        end
    end

    // divided clock never ticks two cycles running unless undivided
    property p_tick_spacing;
        @(posedge CLK) disable iff (RESET)
        (tick && div_sel != '0 && $stable(div_sel)) |=> !tick;
    endproperty
    a_tick_spacing: assert property (p_tick_spacing) else $error("divided tick on consecutive cycles");

    // no conversion runs while unpowered
    property p_unpowered_idle;
        @(posedge CLK) disable iff (RESET)
        !power |=> (state_q == ACS_IDLE) && !ANALOG.sample && !ANALOG.convert;
    endproperty
    a_unpowered_idle: assert property (p_unpowered_idle) else $error("conversion active without power");

    // undivided clock: exactly four sample cycles then convert
    property p_sample_len;
        @(posedge CLK) disable iff (RESET || !power)
        (start_fall && div_sel == '0) |=> (state_q == ACS_SAMPLE)[*4] ##1 (state_q == ACS_CONVERT);
    endproperty
    a_sample_len: assert property (p_sample_len) else $error("sample phase not four periods");

    // whole conversion spans sixteen divided periods
    property p_total_len;
        @(posedge CLK) disable iff (RESET)
        done_evt |-> busy_cyc_q == 12'((16 << div_sel) - 1);
    endproperty
    a_total_len: assert property (p_total_len) else $error("conversion length wrong");

    // register bus never waits on the converter
    property p_no_stall;
        @(posedge CLK) disable iff (RESET)
        (busy && PSEL && PENABLE) |-> PREADY;
    endproperty
    a_no_stall: assert property (p_no_stall) else $error("bus stalled during conversion");

    // start pulse end raises busy on the next edge
    property p_busy_rise;
        @(posedge CLK) disable iff (RESET)
        start_fall |=> busy && ANALOG.sample;
    endproperty
    a_busy_rise: assert property (p_busy_rise) else $error("busy not raised after start pulse");

    // busy drops and flag sets with the stored result
    property p_done;
        @(posedge CLK) disable iff (RESET)
        done_evt |=> !busy && int_stat_q && (res_lo_q[7:4] == (fmt ? $past(code_sync_q[7:4]) : $past(code_sync_q[3:0])));
    endproperty
    a_done: assert property (p_done) else $error("completion effects missing");

    // enabled completion raises the request next cycle
    property p_irq_raise;
        @(posedge CLK) disable iff (RESET)
        (done_evt && int_en_q && gie_q && !wr_acc) |=> IRQ;
    endproperty
    a_irq_raise: assert property (p_irq_raise) else $error("interrupt not raised");

    // either enable low keeps the request off
    property p_irq_gate;
        @(posedge CLK) disable iff (RESET)
        (!gie_q || !int_en_q) |-> !IRQ;
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("interrupt leaked past enables");

    // right aligned result keeps top nibble zero
    property p_format;
        @(posedge CLK) disable iff (RESET)
        (done_evt && fmt) |=> res_hi_q == {4'h0, $past(code_sync_q[11:8])};
    endproperty
    a_format: assert property (p_format) else $error("right aligned result wrong");

    // external channel connected only for source zero
    property p_source;
        @(posedge CLK) disable iff (RESET)
        (src_sel != `ACS_SRC_EXTERNAL) |-> !ANALOG.channel_connect;
    endproperty
    a_source: assert property (p_source) else $error("external channel left connected");

endmodule

// ### verification/adc_conversion_sequencer_tb_top.sv
// self-checking bench for the conversion sequencer: apb driver, result notes in queues, output watcher
// assumes acs_top with default parameters, zero wait state apb slave and the register map of acs_regs.svh
`include "acs_regs.svh"

module adc_conversion_sequencer_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import acs_pkg::*;

    // expected response of one apb transfer
    typedef struct packed {
        logic rd;
        logic err;
        logic [31:0] data;
    } acs_note_s;

    localparam int SETTLE_CYCLES = 20;

    logic CLK;
    logic RESET;
    logic PSEL;
    logic PENABLE;
    logic PWRITE;
    logic [7:0] PADDR;
    logic [31:0] PWDATA;
    logic [31:0] PRDATA;
    logic PREADY;
    logic PSLVERR;
    acs_analog_s ANALOG;
    logic [11:0] ADC_CODE;
    logic IRQ;

    acs_note_s note_q[$];
    int time_q[$];
    acs_note_s note;
    int exp_div;
    int err_total = 0;
    int n_compared = 0;
    int s_cnt = 0;
    int c_cnt = 0;
    int t_cnt = 0;
    logic [7:0] offs[9] = '{`ACS_OFF_CTRL0, `ACS_OFF_CTRL1, `ACS_OFF_CTRL2, `ACS_OFF_RES_HI, `ACS_OFF_RES_LO,
                            `ACS_OFF_INT_STAT, `ACS_OFF_INT_CLR, `ACS_OFF_INT_EN, `ACS_OFF_GIE};

    acs_top u_dut (
        .CLK(CLK),
        .RESET(RESET),
        .PSEL(PSEL),
        .PENABLE(PENABLE),
        .PWRITE(PWRITE),
        .PADDR(PADDR),
        .PWDATA(PWDATA),
        .PRDATA(PRDATA),
        .PREADY(PREADY),
        .PSLVERR(PSLVERR),
        .ANALOG(ANALOG),
        .ADC_CODE(ADC_CODE),
        .IRQ(IRQ)
    );

    // system clock, 5 ns period
    initial CLK = 1'b0;
    always #2.5 CLK = ~CLK;

    task mism(input string m);
        $display("MISMATCH at %0t: %s", $time, m);
        err_total++;
    endtask

    task results;
        $display("counts: compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task chk(input logic ok, input string m);
        n_compared++;
        if (ok !== 1'b1) begin
            mism(m);
        end
    endtask

    // one apb transfer; the expected response goes to the note queue
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] e, input logic er);
        int n;
        note_q.push_back(acs_note_s'{!w, er, e});
        PSEL <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLK);
        PENABLE <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge CLK);
            if (PREADY === 1'b1) break;
        end
        if (n == 50) begin
            mism("apb ready never came");
            results();
        end
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        @(posedge CLK);
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d, input logic er = 1'b0);
        apb(1'b1, a, d, 32'h0, er);
    endtask

    task rd(input logic [7:0] a, input logic [31:0] e, input logic er = 1'b0);
        apb(1'b0, a, 32'h0, e, er);
    endtask

    // waits for a whole conversion to pass, bounded
    task wait_done;
        int n;
        logic seen;
        seen = 1'b0;
        for (n = 0; n < 5000; n++) begin
            @(posedge CLK);
            if (ANALOG.sample === 1'b1 || ANALOG.convert === 1'b1) seen = 1'b1;
            else if (seen) break;
        end
        if (n == 5000) begin
            mism("conversion never finished");
            results();
        end
    endtask

    // one conversion with a given divider, format, interrupt gate and channel
    task conv(input int div, input logic fmt, input logic gie, input logic [3:0] ch);
        logic [11:0] code;
        logic [31:0] hi;
        logic [31:0] lo;
        code = 12'($urandom);
        ADC_CODE <= code;
        wr(`ACS_OFF_GIE, {31'h0, gie});
        wr(`ACS_OFF_CTRL1, {29'h0, 3'(div)});
        wr(`ACS_OFF_CTRL0, {24'h0, ch, 1'b0, fmt, 2'b11});
        time_q.push_back(div);
        wr(`ACS_OFF_CTRL0, {24'h0, ch, 1'b0, fmt, 2'b01});
        rd(`ACS_OFF_CTRL0, {24'h0, ch, 1'b1, fmt, 2'b01});
        wait_done();
        hi = fmt ? {28'h0, code[11:8]} : {24'h0, code[11:4]};
        lo = fmt ? {24'h0, code[7:0]} : {24'h0, code[3:0], 4'h0};
        rd(`ACS_OFF_RES_HI, hi);
        wr(`ACS_OFF_RES_HI, ~hi);
        rd(`ACS_OFF_RES_HI, hi);
        rd(`ACS_OFF_RES_LO, lo);
        rd(`ACS_OFF_INT_STAT, 32'h1);
        rd(`ACS_OFF_CTRL0, {24'h0, ch, 1'b0, fmt, 2'b01});
        chk(IRQ === gie, "interrupt level after completion");
        wr(`ACS_OFF_INT_CLR, 32'h1);
        rd(`ACS_OFF_INT_STAT, 32'h0);
        chk(IRQ === 1'b0, "interrupt stays after clear");
        $display("test conversion div %0d done", div);
    endtask

    // watcher: apb responses and phase lengths against the oldest notes
    always @(posedge CLK) begin
        if (PSEL && PENABLE && PREADY) begin
            if (note_q.size() == 0) begin
                mism("transfer with no note");
            end else begin
                note = note_q.pop_front();
                n_compared++;
                if (PSLVERR !== note.err || (note.rd && PRDATA !== note.data)) begin
                    mism($sformatf("apb addr %0h data %0h err %0b", PADDR, PRDATA, PSLVERR));
                end
            end
        end
        if (ANALOG.sample === 1'b1) s_cnt++;
        if ((ANALOG.sample === 1'b1 || ANALOG.convert === 1'b1) && ANALOG.clk_tick === 1'b1) t_cnt++;
        if (ANALOG.convert === 1'b1) begin
            c_cnt++;
        end else if (c_cnt != 0) begin
            n_compared++;
            if (time_q.size() == 0) begin
                mism("conversion with no note");
            end else begin
                exp_div = time_q.pop_front();
                if (s_cnt != (4 << exp_div) || c_cnt != (12 << exp_div)) begin
                    mism($sformatf("phase lengths %0d and %0d", s_cnt, c_cnt));
                end
                if (t_cnt != `ACS_TOTAL_PERIODS) begin
                    mism($sformatf("conversion clock ticks %0d", t_cnt));
                end
            end
            s_cnt = 0;
            c_cnt = 0;
            t_cnt = 0;
        end else if (ANALOG.sample !== 1'b1) begin
            // an aborted sampling phase leaves no count behind
            s_cnt = 0;
            t_cnt = 0;
        end
    end

    // main sequence
    initial begin
        logic [3:0] ch;
        logic [31:0] d;
        RESET = 1'b1;
        PSEL = 1'b0;
        PENABLE = 1'b0;
        PWRITE = 1'b0;
        PADDR = 8'h00;
        PWDATA = 32'h0;
        ADC_CODE = 12'h000;
        void'($urandom(40));
        repeat (16) @(posedge CLK);
        RESET <= 1'b0;
        @(posedge CLK);
        // reset values and an unmapped place
        foreach (offs[i]) rd(offs[i], 32'h0);
        rd(8'h40, 32'h0, 1'b1);
        wr(8'h40, 32'hFF, 1'b1);
        chk(ANALOG.power === 1'b0, "converter powered after reset");
        $display("test reset values done");
        // start pulse while unpowered is ignored
        wr(`ACS_OFF_CTRL0, 32'h2);
        wr(`ACS_OFF_CTRL0, 32'h0);
        repeat (4) @(posedge CLK);
        chk(ANALOG.sample === 1'b0 && ANALOG.convert === 1'b0, "conversion while unpowered");
        rd(`ACS_OFF_CTRL0, 32'h0);
        $display("test unpowered start done");
        // source routing over every source code
        ch = 4'($urandom);
        wr(`ACS_OFF_CTRL0, {24'h0, ch, 4'h1});
        for (int s = 0; s < 16; s++) begin
            wr(`ACS_OFF_CTRL1, {24'h0, 4'(s), 4'h0});
            chk(ANALOG.channel_connect === (s == 0), "channel connection");
            chk(ANALOG.channel === ch, "channel number");
            chk(ANALOG.source === 4'(s), "source code");
        end
        d = $urandom & 32'h3F;
        wr(`ACS_OFF_CTRL2, d);
        rd(`ACS_OFF_CTRL2, d);
        chk(ANALOG.ref_sel === d[1:0] && ANALOG.amp_gain === d[5:4] && ANALOG.amp_en === d[2], "reference");
        chk(ANALOG.amp_in === d[3], "amplifier input");
        $display("test routing done");
        // settle after power up, then conversions at every divider code
        repeat (SETTLE_CYCLES) @(posedge CLK);
        wr(`ACS_OFF_INT_EN, 32'h1);
        for (int v = 0; v < 8; v++) begin
            conv(v, v[0], v[1], 4'($urandom));
        end
        // code 7 is the only divider in the allowed period range at 200 MHz
        conv(7, 1'b1, 1'b1, 4'($urandom));
        // power drop during sampling aborts with no result and no flag
        rd(`ACS_OFF_INT_CLR, 32'h0);
        wr(`ACS_OFF_CTRL0, 32'h3);
        wr(`ACS_OFF_CTRL0, 32'h1);
        rd(`ACS_OFF_CTRL0, 32'h9);
        wr(`ACS_OFF_CTRL0, 32'h0);
        repeat (2100) @(posedge CLK);
        chk(ANALOG.power === 1'b0 && ANALOG.sample === 1'b0 && ANALOG.convert === 1'b0, "power stays on");
        rd(`ACS_OFF_INT_STAT, 32'h0);
        rd(`ACS_OFF_CTRL0, 32'h0);
        chk(IRQ === 1'b0, "interrupt after aborted conversion");
        $display("test shutdown done");
        results();
    end
endmodule
